// *** verilog/adc_port_pkg.sv ***
// Shared constants and types of the converter output port and its host controller.
// Contract
// - Slave, normal polarity: data changes on rising clock.
// - Slave, inverted polarity: data changes on falling clock.
// - Parallel mode puts the result on the bus.
// - Clock pin: device drives as master, host as slave.
// - Master frame sync active while serial data valid.
// - Unfinished slave read at completion: drop, pulse error.
// - Busy high from start until result latched.
// - Host takes busy falling edge as data ready.
// - Output bus enabled only while select and read low; in serial mode the frame sync (master) or read error (slave) pin stays driven.
// - Slave clock edges count only while selected.
// - Reset pin high holds device, aborts conversion.
// - Reset pin falling starts calibration, busy high.
// - Power-down finishes current conversion, refuses new ones.
// - Select low: master clock out; high: external clock.
// - Result shifts out most significant bit first.
// - Master data stable across both own clock edges.
// - Falling convert start edge begins a conversion.
package adc_port_pkg;
  localparam int RES_W = 16;
  localparam int CNT_W = 8;
  localparam int BIT_W = 5;
  localparam int CLK_NS = 50;
  localparam int CONV_TIME_NS = 400;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_TIME_NS = 2000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNV_LOW_NS = 200;
  localparam int CNV_LOW_CYCLES = (CNV_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Long enough for a bit to cross both pin synchronisers before the host samples it.
  localparam int HSCLK_HALF_NS = 600;
  localparam int HSCLK_HALF_CYCLES = (HSCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNV_LAST = CNT_W'(CNV_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HSCLK_HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] TICK_LAST = 8'h01;
  localparam logic [CNT_W-1:0] ERR_PULSE = 8'h04;
  localparam logic [CNT_W-1:0] PAR_WAIT = 8'h0C;
  localparam logic [BIT_W-1:0] BIT_COUNT = BIT_W'(RES_W);
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam int SDO_BIT = 8;
  localparam int SYNC_BIT = 10;
  localparam int RDERR_BIT = 11;
  localparam int DEV_PIN_N = 10;
  localparam logic [DEV_PIN_N-1:0] DEV_PIN_INIT = 10'h380;
  localparam int HOST_PIN_N = RES_W + 2;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_EN_OFS = 8'h0C;
  localparam logic [7:0] INT_CLR_OFS = 8'h10;
  localparam logic [7:0] RESULT_OFS = 8'h14;
  localparam logic [7:0] STATE_OFS = 8'h18;
  localparam int CTRL_W = 6;
  localparam int CTRL_SER = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_ISCLK = 2;
  localparam int CTRL_ISYNC = 3;
  localparam int CTRL_PD = 4;
  localparam int CTRL_RST = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam int CMD_START = 0;
  localparam int CMD_ABORT = 1;
  localparam int ST_W = 2;
  localparam int ST_DONE = 0;
  localparam int ST_RDERR = 1;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0, DEV_CONV = 2'h1, DEV_CAL = 2'h3, DEV_HELD = 2'h2
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_WAIT_HI = 3'h3, H_WAIT_LO = 3'h2,
    H_READ = 3'h6, H_FINISH = 3'h7
  } host_state_t;
  function automatic logic rose(logic prev, logic now);
    return !prev && now;
  endfunction
  function automatic logic fell(logic prev, logic now);
    return prev && !now;
  endfunction
endpackage

// *** verilog/adc_link_if.sv ***
// Pin-level link between the converter end and its host controller.
`timescale 1ns/1ns
interface adc_link_if;
  import adc_port_pkg::*;
  logic convert_start_n;
  logic cs_n;
  logic rd_n;
  logic converter_reset;
  logic power_down_in;
  logic serial_parallel_select;
  logic clock_source_select;
  logic serial_clock_invert;
  logic frame_sync_invert;
  logic busy;
  logic [RES_W-1:0] data_out;
  logic [RES_W-1:0] data_oe_n;
  logic [RES_W-1:0] data_pins;
  logic dev_sclk;
  logic dev_sclk_oe_n;
  logic host_sclk;
  logic host_sclk_oe_n;
  logic sclk_pin;
  // Undriven pins settle low, as with a weak pull-down.
  assign data_pins = data_out & ~data_oe_n;
  assign sclk_pin = (!dev_sclk_oe_n && dev_sclk) || (!host_sclk_oe_n && host_sclk);
  modport device (
    input convert_start_n, cs_n, rd_n, converter_reset, power_down_in,
    input serial_parallel_select, clock_source_select, serial_clock_invert,
    input frame_sync_invert, sclk_pin,
    output busy, data_out, data_oe_n, dev_sclk, dev_sclk_oe_n
  );
  modport host (
    output convert_start_n, cs_n, rd_n, converter_reset, power_down_in,
    output serial_parallel_select, clock_source_select, serial_clock_invert,
    output frame_sync_invert, host_sclk, host_sclk_oe_n,
    input busy, data_pins, sclk_pin
  );
endinterface

// *** verilog/pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_regs_t;
  sync_regs_t r;
  sync_regs_t n;
  always_comb begin
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= {INIT, INIT, INIT, INIT};
    end else begin
      r <= n;
    end
  end
  assign level = r.lvl;
endmodule

// *** verilog/adc_device_end.sv ***
// Converter end: conversion sequencing, calibration and parallel or serial result output.
`timescale 1ns/1ns
module adc_device_end (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [adc_port_pkg::RES_W-1:0] sample_in,
  output logic conversions_refused,
  adc_link_if.device link
);
  import adc_port_pkg::*;

  typedef struct packed {
    dev_state_t st;
    logic [CNT_W-1:0] cnt;
    logic cnv_q;
    logic sclk_q;
    logic [RES_W-1:0] sh;
    logic sdo;
    logic [BIT_W-1:0] bitn;
    logic fresh;
    logic [CNT_W-1:0] err_cnt;
    logic frame;
    logic [CNT_W-1:0] tick;
    logic [1:0] phase;
    logic msclk;
    logic busy;
    logic refused;
    logic [RES_W-1:0] dout;
    logic [RES_W-1:0] oe_n;
    logic sclk_out;
    logic sclk_oe_n;
  } dev_regs_t;

  dev_regs_t r;
  dev_regs_t n;
  logic [DEV_PIN_N-1:0] pins;
  logic cnv_s;
  logic cs_s;
  logic rd_s;
  logic rst_s;
  logic pd_s;
  logic ser_s;
  logic ext_s;
  logic isclk_s;
  logic isync_s;
  logic sclk_s;
  logic read_en;
  logic gated_edge;
  logic slave;
  logic master;

  pin_sync #(
    .W(DEV_PIN_N),
    .INIT(DEV_PIN_INIT)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin({link.convert_start_n, link.cs_n, link.rd_n, link.converter_reset,
          link.power_down_in, link.serial_parallel_select, link.clock_source_select,
          link.serial_clock_invert, link.frame_sync_invert, link.sclk_pin}),
    .level(pins)
  );

  assign {cnv_s, cs_s, rd_s, rst_s, pd_s, ser_s, ext_s, isclk_s, isync_s, sclk_s} = pins;
  assign read_en = !cs_s && !rd_s;
  assign slave = ser_s && ext_s;
  assign master = ser_s && !ext_s;
  // The clock edge is looked for only while selected, so a shared clock cannot shift us.
  assign gated_edge = !cs_s && (isclk_s ? fell(r.sclk_q, sclk_s) : rose(r.sclk_q, sclk_s));

  always_comb begin
    n = r;
    n.cnv_q = cnv_s;
    n.sclk_q = sclk_s;
    if (r.err_cnt != '0) begin
      n.err_cnt = r.err_cnt - 1'b1;
    end

    // Slave read: each active edge puts out the next bit.
    if (slave && gated_edge && read_en && r.bitn != BIT_COUNT) begin
      n.sdo = r.sh[RES_W-1];
      n.sh = {r.sh[RES_W-2:0], 1'b0};
      n.bitn = r.bitn + 1'b1;
    end
    if (slave && r.bitn == BIT_COUNT) begin
      n.fresh = 1'b0;
    end

    // Master read: four phases per bit, data moves a phase before the rising edge.
    if (master) begin
      if (!r.frame && read_en && r.fresh && r.st == DEV_IDLE) begin
        n.frame = 1'b1;
        n.tick = '0;
        n.phase = PH_DATA;
        n.bitn = '0;
      end else if (r.frame) begin
        if (r.tick == TICK_LAST) begin
          n.tick = '0;
          n.phase = r.phase + 1'b1;
          if (r.phase == PH_DATA) begin
            n.sdo = r.sh[RES_W-1];
            n.sh = {r.sh[RES_W-2:0], 1'b0};
            n.bitn = r.bitn + 1'b1;
          end else if (r.phase == PH_RISE) begin
            n.msclk = 1'b1;
          end else if (r.phase == PH_FALL) begin
            n.msclk = 1'b0;
            if (r.bitn == BIT_COUNT) begin
              n.frame = 1'b0;
              n.fresh = 1'b0;
            end
          end
        end else begin
          n.tick = r.tick + 1'b1;
        end
      end
    end else begin
      n.frame = 1'b0;
      n.msclk = 1'b0;
    end

    // Conversion sequencing; the reset pin overrides everything.
    if (rst_s) begin
      n.st = DEV_HELD;
      n.busy = 1'b0;
      n.cnt = '0;
    end else begin
      unique case (r.st)
        DEV_HELD: begin
          n.st = DEV_CAL;
          n.busy = 1'b1;
          n.cnt = '0;
        end
        DEV_CAL: begin
          if (r.cnt == CAL_LAST) begin
            n.st = DEV_IDLE;
            n.busy = 1'b0;
          end else begin
            n.cnt = r.cnt + 1'b1;
          end
        end
        DEV_IDLE: begin
          if (fell(r.cnv_q, cnv_s) && !pd_s) begin
            n.st = DEV_CONV;
            n.busy = 1'b1;
            n.cnt = '0;
          end
        end
        DEV_CONV: begin
          // Power-down is not looked at here, so a running conversion finishes unless the reset pin aborts it.
          if (r.cnt == CONV_LAST) begin
            n.st = DEV_IDLE;
            n.busy = 1'b0;
            n.sh = sample_in;
            n.fresh = 1'b1;
            n.bitn = '0;
            n.frame = 1'b0;
            n.msclk = 1'b0;
            if (slave && r.bitn != '0 && r.bitn != BIT_COUNT) begin
              n.err_cnt = ERR_PULSE;
            end
          end else begin
            n.cnt = r.cnt + 1'b1;
          end
        end
      endcase
    end
    n.refused = pd_s || rst_s;

    // Pin drivers, all registered.
    n.sclk_out = n.msclk ^ isclk_s;
    n.sclk_oe_n = !master;
    if (ser_s) begin
      n.dout = '0;
      n.dout[SDO_BIT] = n.sdo;
      n.dout[SYNC_BIT] = n.frame ^ isync_s;
      n.dout[RDERR_BIT] = n.err_cnt != '0;
      n.oe_n = '1;
      n.oe_n[SDO_BIT] = !read_en;
      n.oe_n[SYNC_BIT] = ext_s;
      n.oe_n[RDERR_BIT] = !ext_s;
    end else begin
      n.dout = n.sh;
      n.oe_n = {RES_W{!read_en}};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '0;
      r.cnv_q <= 1'b1;
      r.oe_n <= '1;
      r.sclk_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.busy = r.busy;
  assign link.data_out = r.dout;
  assign link.data_oe_n = r.oe_n;
  assign link.dev_sclk = r.sclk_out;
  assign link.dev_sclk_oe_n = r.sclk_oe_n;
  assign conversions_refused = r.refused;
endmodule

// *** verilog/adc_host_end.sv ***
// Host controller end: APB registers, conversion requests and result reads.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module adc_host_end (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  adc_link_if.host link
);
  import adc_port_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [CTRL_W-1:0] ctrl;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] int_en;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] sh;
    logic [CNT_W-1:0] cnt;
    logic [BIT_W-1:0] bitn;
    logic sclk_q;
    logic err_q;
    logic hsclk;
    logic cnv_n;
    logic sel_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } host_regs_t;

  host_regs_t r;
  host_regs_t n;
  logic [HOST_PIN_N-1:0] pins;
  logic busy_s;
  logic sclk_s;
  logic [RES_W-1:0] data_s;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  logic start;
  logic abort;
  logic inv;

  function automatic logic mapped(logic [7:0] a);
    return a inside {CTRL_OFS, CMD_OFS, STATUS_OFS, INT_EN_OFS, INT_CLR_OFS,
                     RESULT_OFS, STATE_OFS};
  endfunction

  pin_sync #(
    .W(HOST_PIN_N),
    .INIT('0)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin({link.busy, link.sclk_pin, link.data_pins}),
    .level(pins)
  );

  assign {busy_s, sclk_s, data_s} = pins;
  assign inv = r.ctrl[CTRL_ISCLK];

  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    start = 1'b0;
    abort = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.sclk_q = sclk_s;
    n.err_q = data_s[RDERR_BIT];
    // One wait state: pready rises in the second access cycle.
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = !mapped(paddr);
      n.prdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          CTRL_OFS: n.prdata[CTRL_W-1:0] = r.ctrl;
          STATUS_OFS: n.prdata[ST_W-1:0] = r.status;
          INT_EN_OFS: n.prdata[ST_W-1:0] = r.int_en;
          RESULT_OFS: n.prdata[RES_W-1:0] = r.result;
          STATE_OFS: n.prdata[3:0] = {busy_s, r.st};
          default: n.prdata = '0;
        endcase
      end
    end
    if (psel && penable && r.pready && pwrite) begin
      unique case (paddr)
        CTRL_OFS: n.ctrl = pwdata[CTRL_W-1:0];
        CMD_OFS: begin
          start = pwdata[CMD_START];
          abort = pwdata[CMD_ABORT];
        end
        INT_EN_OFS: n.int_en = pwdata[ST_W-1:0];
        INT_CLR_OFS: clr = pwdata[ST_W-1:0];
        default: n.cnt = r.cnt;
      endcase
    end
    if (r.ctrl[CTRL_SER] && r.ctrl[CTRL_EXT] && rose(r.err_q, data_s[RDERR_BIT])) begin
      ev[ST_RDERR] = 1'b1;
    end

    unique case (r.st)
      H_IDLE: begin
        if (start) begin
          n.st = H_START;
          n.cnv_n = 1'b0;
          n.cnt = '0;
        end
      end
      H_START: begin
        if (r.cnt == CNV_LAST) begin
          n.cnv_n = 1'b1;
          n.st = H_WAIT_HI;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      H_WAIT_HI: begin
        if (busy_s) begin
          n.st = H_WAIT_LO;
        end
      end
      H_WAIT_LO: begin
        if (!busy_s) begin
          n.st = H_READ;
          n.sel_n = 1'b0;
          n.cnt = '0;
          n.bitn = '0;
        end
      end
      H_READ: begin
        if (!r.ctrl[CTRL_SER]) begin
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == PAR_WAIT) begin
            n.sh = data_s;
            n.st = H_FINISH;
          end
        end else if (!r.ctrl[CTRL_EXT]) begin
          if (inv ? fell(r.sclk_q, sclk_s) : rose(r.sclk_q, sclk_s)) begin
            n.sh = {r.sh[RES_W-2:0], data_s[SDO_BIT]};
            n.bitn = r.bitn + 1'b1;
          end
        end else if (r.cnt == HALF_LAST) begin
          // Clock toggles only while selected; sampling on the return to the idle level.
          n.cnt = '0;
          n.hsclk = !r.hsclk;
          if (r.hsclk != inv) begin
            n.sh = {r.sh[RES_W-2:0], data_s[SDO_BIT]};
            n.bitn = r.bitn + 1'b1;
          end
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
        if (r.bitn == BIT_COUNT) begin
          n.st = H_FINISH;
        end
      end
      H_FINISH: begin
        n.result = r.sh;
        n.sel_n = 1'b1;
        ev[ST_DONE] = 1'b1;
        n.st = H_IDLE;
      end
    endcase
    if (r.st != H_READ) begin
      n.hsclk = inv;
    end
    if (abort) begin
      n.st = H_IDLE;
      n.cnv_n = 1'b1;
      n.sel_n = 1'b1;
    end
    // A new event wins over a clear in the same cycle.
    n.status = (r.status & ~clr) | ev;
    n.irq = |(n.status & n.int_en);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '0;
      r.ctrl <= CTRL_RESET;
      r.cnv_n <= 1'b1;
      r.sel_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign link.convert_start_n = r.cnv_n;
  assign link.cs_n = r.sel_n;
  assign link.rd_n = r.sel_n;
  assign link.converter_reset = r.ctrl[CTRL_RST];
  assign link.power_down_in = r.ctrl[CTRL_PD];
  assign link.serial_parallel_select = r.ctrl[CTRL_SER];
  assign link.clock_source_select = r.ctrl[CTRL_EXT];
  assign link.serial_clock_invert = r.ctrl[CTRL_ISCLK];
  assign link.frame_sync_invert = r.ctrl[CTRL_ISYNC];
  assign link.host_sclk = r.hsclk;
  assign link.host_sclk_oe_n = !(r.ctrl[CTRL_SER] && r.ctrl[CTRL_EXT]);
endmodule

// *** verification/adc_link_chk.sv ***
// Concurrent checks on the link between the converter end and the host end.
`timescale 1ns/1ns
module adc_link_chk
  import adc_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic converter_reset,
  input wire logic power_down_in,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic serial_clock_invert,
  input wire logic frame_sync_invert,
  input wire logic busy,
  input wire logic [RES_W-1:0] data_out,
  input wire logic [RES_W-1:0] data_oe_n,
  input wire logic dev_sclk,
  input wire logic dev_sclk_oe_n,
  input wire logic sclk_pin
);
  logic [7:0] quiet_r;
  logic [7:0] pd_r;
  logic [7:0] act_r;
  localparam logic [RES_W-1:0] FLAG_PINS = RES_W'((1 << SYNC_BIT) | (1 << RDERR_BIT));
  logic [7:0] cause_r;
  logic [7:0] par_r;
  logic [RES_W-1:0] flag_pins;
  logic sclk_q_r;
  logic err_pin;
  logic sdo_pin;
  logic act_edge;
  assign err_pin = data_out[RDERR_BIT] & ~data_oe_n[RDERR_BIT];
  assign sdo_pin = data_out[SDO_BIT] & ~data_oe_n[SDO_BIT];
  // Frame sync (master) or read error (slave) stays driven in serial mode, read or not, until the pins resync.
  assign flag_pins = (serial_parallel_select || par_r < 8'h06) ? FLAG_PINS : '0;
  // The pin synchronisers delay every edge by a few cycles, so bounds carry that slack.
  assign act_edge = (sclk_pin != sclk_q_r) && (sclk_pin != serial_clock_invert);
  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      quiet_r <= 8'h00;
      pd_r <= 8'h00;
      act_r <= 8'hFF;
      cause_r <= 8'hFF;
      par_r <= 8'hFF;
      sclk_q_r <= 1'b0;
    end else begin
      quiet_r <= converter_reset ? 8'h00 : sat(quiet_r);
      pd_r <= power_down_in ? sat(pd_r) : 8'h00;
      act_r <= act_edge ? 8'h00 : sat(act_r);
      cause_r <= (!convert_start_n || converter_reset) ? 8'h00 : sat(cause_r);
      par_r <= serial_parallel_select ? 8'h00 : sat(par_r);
      sclk_q_r <= sclk_pin;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence conv_run;
    busy[*8] ##1 !busy;
  endsequence
  sequence cal_run;
    ##[1:8] $rose(busy) ##0 busy[*8];
  endsequence
  a_pins_released: assert property ((cs_n || rd_n)[*6] |->
      &(data_oe_n | flag_pins))
    else $error("data pins driven while deselected");
  a_busy_cause: assert property ($rose(busy) |-> cause_r <= 8'h08)
    else $error("busy rose without a start or reset release");
  a_conv_busy_len: assert property ($rose(busy) && quiet_r > 8'h14 |-> conv_run)
    else $error("conversion busy span wrong");
  a_cal_busy: assert property ($fell(converter_reset) |-> cal_run)
    else $error("no calibration busy after reset release");
  a_held_idle: assert property (converter_reset[*6] |-> !busy)
    else $error("busy while converter held in reset");
  a_pd_refuse: assert property ($rose(busy) |-> pd_r < 8'h08)
    else $error("conversion started in power down");
  a_slave_release: assert property (clock_source_select[*6] |-> dev_sclk_oe_n)
    else $error("device drives clock in slave mode");
  a_master_stable: assert property (serial_parallel_select && !dev_sclk_oe_n &&
      $changed(dev_sclk) && $stable(serial_clock_invert) |-> $stable(sdo_pin))
    else $error("master data moved on a clock edge");
  a_sync_active: assert property (serial_parallel_select && !dev_sclk_oe_n &&
      $stable(serial_clock_invert) && $rose(dev_sclk ^ serial_clock_invert) |->
      !data_oe_n[SYNC_BIT] && (data_out[SYNC_BIT] != frame_sync_invert))
    else $error("frame sync inactive during master bit");
  a_slave_edge: assert property (serial_parallel_select && clock_source_select && !cs_n &&
      !data_oe_n[SDO_BIT] && $stable(data_oe_n[SDO_BIT]) && !busy && !$fell(busy) &&
      $changed(data_out[SDO_BIT]) |-> act_r <= 8'h07)
    else $error("slave data changed away from active edge");
  a_err_pulse: assert property (serial_parallel_select && clock_source_select &&
      $rose(err_pin) |-> err_pin[*4] ##1 !err_pin)
    else $error("read error pulse length wrong");
endmodule

// *** verification/adc_host_output_port_bench.sv ***
// Self-checking bench for the converter end and host end joined by their link.
`timescale 1ns/1ns
module adc_host_output_port_bench;
  import adc_port_pkg::*;
  logic ref_clk;
  logic reset;
  logic psel, penable, pwrite, pready, pslverr, irq, refused, slv_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [RES_W-1:0] sample_in;
  int err_count, compares, busy_rises, n;
  adc_link_if adc_link_if_i ();
  adc_device_end adc_device_end_i (.ref_clk(ref_clk), .reset(reset), .sample_in(sample_in),
    .conversions_refused(refused), .link(adc_link_if_i.device));
  adc_host_end adc_host_end_i (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(adc_link_if_i.host));
  adc_link_chk adc_link_chk_i (.ref_clk(ref_clk), .reset(reset),
    .convert_start_n(adc_link_if_i.convert_start_n), .cs_n(adc_link_if_i.cs_n),
    .rd_n(adc_link_if_i.rd_n), .converter_reset(adc_link_if_i.converter_reset),
    .power_down_in(adc_link_if_i.power_down_in),
    .serial_parallel_select(adc_link_if_i.serial_parallel_select),
    .clock_source_select(adc_link_if_i.clock_source_select),
    .serial_clock_invert(adc_link_if_i.serial_clock_invert),
    .frame_sync_invert(adc_link_if_i.frame_sync_invert), .busy(adc_link_if_i.busy),
    .data_out(adc_link_if_i.data_out), .data_oe_n(adc_link_if_i.data_oe_n),
    .dev_sclk(adc_link_if_i.dev_sclk), .dev_sclk_oe_n(adc_link_if_i.dev_sclk_oe_n),
    .sclk_pin(adc_link_if_i.sclk_pin));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge adc_link_if_i.busy) busy_rises++;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; an idle cycle follows so the strobe is never reassigned in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      w++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h2, w);
    rd_v = prdata;
    slv_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic convert(input logic [31:0] ctrl, input logic [15:0] val);
    int k;
    logic [31:0] idle_v;
    k = 0;
    idle_v = 32'(ctrl[CTRL_SER] && !ctrl[CTRL_EXT] && ctrl[CTRL_ISYNC]) << SYNC_BIT;
    sample_in <= val;
    apb(1'b1, CTRL_OFS, ctrl);
    apb(1'b1, CMD_OFS, 32'h1);
    rd_v = 32'h0;
    while (rd_v[ST_DONE] !== 1'b1 && k < 300) begin
      apb(1'b0, STATUS_OFS, 32'h0);
      k++;
    end
    chk("irq on done", 32'h1, irq);
    apb(1'b0, RESULT_OFS, 32'h0);
    chk("result", {16'h0, val}, rd_v);
    apb(1'b1, INT_CLR_OFS, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("irq after clear", 32'h0, irq);
    chk("pins idle", idle_v, adc_link_if_i.data_pins);
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(CLK_NS * 30000);
    err_count++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sample_in = 16'h0000;
    {err_count, compares, busy_rises} = '0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd_v);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, slv_v);
    apb(1'b1, STATUS_OFS, 32'h3);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status read only", 32'h0, rd_v);
    apb(1'b1, INT_EN_OFS, 32'h3);
    apb(1'b0, INT_EN_OFS, 32'h0);
    chk("int enable", 32'h3, rd_v);
    $display("register test done");
    convert(32'h0, 16'hA5C3);
    convert(32'h0, 16'h5A3C);
    convert(32'h1, 16'h3C96);
    convert(32'h9, 16'h8001);
    convert(32'h3, 16'hC3A5);
    convert(32'h7, 16'h0FF0);
    $display("transfer test done");
    sample_in <= 16'h6E11;
    apb(1'b1, CMD_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h10);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, RESULT_OFS, 32'h0);
    chk("finished in power down", 32'h6E11, rd_v);
    chk("refused flag", 32'h1, refused);
    n = busy_rises;
    apb(1'b1, CMD_OFS, 32'h1);
    repeat (40) @(posedge ref_clk);
    chk("no conversion in power down", n, busy_rises);
    apb(1'b1, CMD_OFS, 32'h2);
    apb(1'b1, INT_CLR_OFS, 32'h3);
    convert(32'h0, 16'h1234);
    $display("power down test done");
    apb(1'b1, CTRL_OFS, 32'h20);
    repeat (8) @(posedge ref_clk);
    chk("held refused", 32'h1, refused);
    chk("held not busy", 32'h0, adc_link_if_i.busy);
    apb(1'b1, CTRL_OFS, 32'h0);
    n = 0;
    while (adc_link_if_i.busy !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (adc_link_if_i.busy === 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("calibration busy span", CAL_CYCLES, n);
    $display("calibration test done");
    apb(1'b1, CTRL_OFS, 32'h3);
    sample_in <= 16'hBEEF;
    apb(1'b1, CMD_OFS, 32'h1);
    repeat (60) @(posedge ref_clk);
    apb(1'b1, CMD_OFS, 32'h2);
    apb(1'b1, CMD_OFS, 32'h1);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("incomplete read flag", 32'h1, rd_v[ST_RDERR]);
    apb(1'b1, CMD_OFS, 32'h2);
    apb(1'b1, INT_CLR_OFS, 32'h3);
    $display("read error test done");
    complete_run();
  end
endmodule
